//--- bspc_pkg.sv
/*
  constants, state and pin types for the backplane serial phy pin control.
  assumes a 200 MHz core clock; imported by bspc_pin_ctrl, the link model and the bench, not by the sync files.
*/
package bspc_pkg;
  // core clock
  localparam int CLK_PERIOD_NS = 5;
  // receive prefix drops after this long without a line transition
  localparam int RX_IDLE_NS = 200;
  localparam int RX_IDLE_CYC = (RX_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRI_W = 4;
  localparam logic [PRI_W-1:0] PRI_RESET = 4'h0;
  localparam logic [3:0] CABLE_REQ_BITS = 4'h7;
  localparam logic [3:0] BACKPLANE_REQ_BITS = 4'hb;
  // codes the phy drives on the control pair
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [1:0] CTL_GRANT = 2'h3;
  // codes the link drives on the control pair after a grant
  localparam logic [1:0] LINK_IDLE = 2'h0;
  localparam logic [1:0] LINK_TX = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_GRANT, ST_LINK, ST_RECV} bspc_state_e;

  typedef struct packed {
    logic oscHigh;
    logic oscLow;
    logic rateSel;
    logic lreq;
    logic rxData;
    logic rxStrobe;
    logic [1:0] ctl;
    logic [1:0] data;
    logic testDis;
    logic factTest;
    logic extPriEn;
    logic reqFmt;
    logic [PRI_W-1:0] extPri;
  } bspc_pins_s;
endpackage

//--- bspc_sync_if.sv
/*
  carrier between the pin synchroniser and the phy control logic.
  assumes the syncer and user agree on the width W.
*/
`timescale 1ns/1ps
interface bspc_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport syncer (input raw, output level, rise, fall);
  modport user (output raw, input level, rise, fall);
endinterface

//--- bspc_sync.sv
/*
  two-flop synchroniser bank with edge detection after the second flop.
  assumes raw inputs are asynchronous to clk; no reset, data path only.
*/
`timescale 1ns/1ps
module bspc_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk,
  // pins in, synchronised levels and edges out
  bspc_sync_if.syncer sif
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clk) begin
    meta_q <= sif.raw;
    sync_q <= meta_q;
    prev_q <= sync_q;
  end

  assign sif.level = sync_q;
  assign sif.rise = sync_q & ~prev_q;
  assign sif.fall = ~sync_q & prev_q;
endmodule

//--- bspc_pin_ctrl.sv
/*
  pin-level control of a single-port backplane serial phy: system clocks,
  link handshake, data-strobe transmit and receive, priority and test pins.
  assumes all pins but reset, priorityWriteValid and priorityWriteValue are asynchronous to clk and the bench resolves the
  two-way link pins from linkOeN.
*/
// Functional notes
// RL1 - link raises its request pin to ask the phy for a service
// RL2 - external driver enable goes low to enable transmit data and strobe drivers
// RL3 - reset returns all internal logic to its start state; the bspc_sync synchroniser and edge flops have no reset
// RL4 - rate select high means 50 MHz, low means 100 MHz; never floating
// RL5 - phy drive indicator is low while the phy drives link control and data
// RL6 - test disable high puts arbitration clock, indicator, prefix outputs in high impedance
// RL7 - receive prefix flag goes high while an incoming packet arrives
// RL8 - system clock to link is 49.152 or 24.576 MHz, tied to transfers
// RL9 - second system clock is the same clock inverted
// RL10 - outgoing bits serialised on transmit data with data-strobe companion strobe
// RL11 - receive data and receive strobe together decode incoming bits
// RL12 - external priority enable takes priority from external pins, ignoring format select
// RL13 - otherwise format low selects 7-bit request; link writes priority
// RL14 - otherwise format high selects 11-bit request carrying priority dynamically
// RL15 - factory test input held at ground in normal operation
// RL16 - oscillator is 98.304 MHz on high-rate or 49.152 MHz on low-rate input
// RL17 - link control and data lines are two-way, driven by each side in turn
// RL18 - priority is four bits, larger value means higher priority
// RL19 - format and external priority selects change only during reset
`timescale 1ns/1ps
module bspc_pin_ctrl
  import bspc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // oscillator
  input wire logic oscInHighRate,
  input wire logic oscInLowRate,
  input wire logic oscillatorRateSelect,
  // link side
  output logic sysClock,
  output logic invertedSystemClock,
  input wire logic linkRequest,
  input wire logic [1:0] ctlIn,
  output logic [1:0] ctlOut,
  input wire logic [1:0] dataIn,
  output logic [1:0] dataOut,
  output logic linkOeN,
  // backplane serial side
  output logic txSerialData,
  output logic txSerialStrobe,
  output logic extDriverEnableN,
  input wire logic rxSerialData,
  input wire logic rxSerialStrobe,
  // priority and request format
  input wire logic externalPriorityEnable,
  input wire logic [PRI_W-1:0] externalPriorityValue,
  input wire logic requestFormatSelect,
  input wire logic priorityWriteValid,
  input wire logic [PRI_W-1:0] priorityWriteValue,
  output logic [PRI_W-1:0] nodePriority,
  output logic [3:0] busRequestBits,
  // test
  input wire logic testOutputDisable,
  input wire logic factoryTestInput,
  output logic arbitrationClockOut,
  output logic arbitrationClockOeN,
  output logic phyDriveIndicator,
  output logic phyDriveIndicatorOeN,
  output logic receivePrefixFlag,
  output logic receivePrefixFlagOeN
);
  localparam int PW = $bits(bspc_pins_s);

  bspc_sync_if #(.W(PW)) sif ();
  bspc_pins_s pins;
  bspc_pins_s pinsRise;
  bspc_pins_s pinsFall;

  assign sif.raw = {oscInHighRate, oscInLowRate, oscillatorRateSelect, linkRequest, rxSerialData, rxSerialStrobe,
                    ctlIn, dataIn, testOutputDisable, factoryTestInput, externalPriorityEnable,
                    requestFormatSelect, externalPriorityValue};
  assign pins = sif.level;
  assign pinsRise = sif.rise;
  assign pinsFall = sif.fall;

  bspc_sync #(.W(PW)) pinSync (
    .clk(clk),
    .sif(sif)
  );

  // ----------------------------------------
  // static configuration
  // ----------------------------------------
  logic rateLow_q;
  logic extPriEn_q;
  logic reqFmt_q;

  // caught while reset is held, frozen afterwards
  always_ff @(posedge clk) begin
    if (reset) begin
      rateLow_q <= pins.rateSel;   // see RL4
      extPriEn_q <= pins.extPriEn; // see RL19
      reqFmt_q <= pins.reqFmt;
    end
  end

  // ----------------------------------------
  // system clocks
  // ----------------------------------------
  logic sysClk_q;
  logic invSysClk_q;
  logic arbClk_q;
  logic oscTick;
  logic sysTick;

  assign oscTick = rateLow_q ? pinsRise.oscLow : pinsRise.oscHigh; // see RL16
  assign sysTick = oscTick & ~sysClk_q;

  // divide by two: 49.152 from 98.304, 24.576 from 49.152
  always_ff @(posedge clk) begin
    if (reset) begin
      sysClk_q <= 1'b0;
      invSysClk_q <= 1'b1;
    end else if (oscTick) begin
      sysClk_q <= ~sysClk_q;  // see RL8
      invSysClk_q <= sysClk_q; // see RL9
    end
  end

  // arbitration clock always at 49.152 MHz
  always_ff @(posedge clk) begin
    if (reset) begin
      arbClk_q <= 1'b0;
    end else if (rateLow_q) begin
      arbClk_q <= pins.oscLow;
    end else begin
      arbClk_q <= oscTick ? ~sysClk_q : sysClk_q;
    end
  end

  // ----------------------------------------
  // receive decode and prefix
  // ----------------------------------------
  logic rxEvt;
  logic rxHalf_q;
  logic rxFirst_q;
  logic [1:0] rxPair_q;
  logic rxPrefix_q;
  logic [$clog2(RX_IDLE_CYC+1)-1:0] rxIdle_q;

  // one line transition on either pin per bit
  assign rxEvt = pinsRise.rxData | pinsFall.rxData | pinsRise.rxStrobe | pinsFall.rxStrobe; // see RL11

  always_ff @(posedge clk) begin
    if (reset) begin
      rxHalf_q <= 1'b0;
      rxFirst_q <= 1'b0;
      rxPair_q <= 2'h0;
    end else if (rxEvt) begin
      rxHalf_q <= ~rxHalf_q;
      if (rxHalf_q) begin
        rxPair_q <= {pins.rxData, rxFirst_q};
      end else begin
        rxFirst_q <= pins.rxData;
      end
    end else if (!rxPrefix_q) begin
      rxHalf_q <= 1'b0;
    end
  end

  // a transition wins over the idle timeout
  always_ff @(posedge clk) begin
    if (reset) begin
      rxPrefix_q <= 1'b0;
      rxIdle_q <= '0;
    end else if (rxEvt) begin
      rxPrefix_q <= 1'b1; // see RL7
      rxIdle_q <= '0;
    end else if (rxPrefix_q) begin
      rxIdle_q <= rxIdle_q + 1'b1;
      if (rxIdle_q == ($clog2(RX_IDLE_CYC+1))'(RX_IDLE_CYC - 1)) begin
        rxPrefix_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // link port state
  // ----------------------------------------
  bspc_state_e state_q;
  logic [1:0] ctlOut_q;
  logic [1:0] dataOut_q;
  logic linkOeN_q;
  logic linkTx;

  assign linkTx = sysTick && state_q == ST_LINK && pins.ctl == LINK_TX;

  // lines turn round between phy and link
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE; // see RL3
      ctlOut_q <= CTL_IDLE;
      dataOut_q <= 2'h0;
      linkOeN_q <= 1'b0;
    end else if (sysTick) begin
      case (state_q)
        ST_IDLE: begin
          if (rxPrefix_q) begin
            state_q <= ST_RECV;
            ctlOut_q <= CTL_RECEIVE;
            dataOut_q <= rxPair_q;
          end else if (pins.lreq) begin
            state_q <= ST_GRANT; // see RL1
            ctlOut_q <= CTL_GRANT;
          end
        end
        ST_GRANT: begin
          state_q <= ST_LINK;
          ctlOut_q <= CTL_IDLE;
          linkOeN_q <= 1'b1; // see RL17
        end
        ST_LINK: begin
          if (pins.ctl == LINK_IDLE) begin
            state_q <= ST_IDLE;
            linkOeN_q <= 1'b0;
          end
        end
        ST_RECV: begin
          if (!rxPrefix_q) begin
            state_q <= ST_IDLE;
            ctlOut_q <= CTL_IDLE;
            dataOut_q <= 2'h0;
          end else begin
            dataOut_q <= rxPair_q;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // transmit serialiser, data-strobe encode
  // ----------------------------------------
  logic txActive_q;
  logic txPending_q;
  logic txNext_q;
  logic txData_q;
  logic txStrobe_q;
  logic txBit;
  logic txStep;
  logic extDrvEnN_q;

  assign txStep = linkTx | (oscTick & txPending_q);
  assign txBit = linkTx ? pins.data[0] : txNext_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      txActive_q <= 1'b0;
      txPending_q <= 1'b0;
      txNext_q <= 1'b0;
      txData_q <= 1'b0;
      txStrobe_q <= 1'b0;
    end else begin
      if (linkTx) begin
        txActive_q <= 1'b1;
        txPending_q <= 1'b1;
        txNext_q <= pins.data[1];
      end else if (oscTick) begin
        txPending_q <= 1'b0;
        if (sysTick) begin
          txActive_q <= 1'b0;
        end
      end
      if (txStep) begin
        txData_q <= txBit; // see RL10
        txStrobe_q <= (txBit == txData_q) ? ~txStrobe_q : txStrobe_q;
      end
    end
  end

  // factory test input high keeps the backplane drivers off
  always_ff @(posedge clk) begin
    if (reset) begin
      extDrvEnN_q <= 1'b1;
    end else begin
      extDrvEnN_q <= ~(txActive_q & ~pins.factTest); // see RL2 see RL15
    end
  end

  // ----------------------------------------
  // priority and request format
  // ----------------------------------------
  logic [PRI_W-1:0] nodePri_q;
  logic [3:0] reqBits_q;
  logic [1:0] priPairs_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      nodePri_q <= PRI_RESET;
      priPairs_q <= 2'h0;
    end else if (extPriEn_q) begin
      nodePri_q <= pins.extPri; // see RL12 see RL18
    end else if (!reqFmt_q) begin
      if (priorityWriteValid) begin
        nodePri_q <= priorityWriteValue; // see RL13
      end
    end else begin
      // backplane request: first two pairs carry the priority, low pair first
      if (state_q == ST_GRANT) begin
        priPairs_q <= 2'h0;
      end else if (linkTx && priPairs_q != 2'h2) begin
        priPairs_q <= priPairs_q + 2'h1;
        if (priPairs_q == 2'h0) begin
          nodePri_q[1:0] <= pins.data; // see RL14
        end else begin
          nodePri_q[3:2] <= pins.data;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reqBits_q <= CABLE_REQ_BITS;
    end else begin
      reqBits_q <= (!extPriEn_q && reqFmt_q) ? BACKPLANE_REQ_BITS : CABLE_REQ_BITS; // see RL13 see RL14
    end
  end

  // ----------------------------------------
  // test outputs
  // ----------------------------------------
  logic testOeN_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      testOeN_q <= 1'b1;
    end else begin
      testOeN_q <= pins.testDis; // see RL6
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sysClock = sysClk_q;
  assign invertedSystemClock = invSysClk_q;
  assign ctlOut = ctlOut_q;
  assign dataOut = dataOut_q;
  assign linkOeN = linkOeN_q;
  assign txSerialData = txData_q;
  assign txSerialStrobe = txStrobe_q;
  assign extDriverEnableN = extDrvEnN_q;
  assign nodePriority = nodePri_q;
  assign busRequestBits = reqBits_q;
  assign arbitrationClockOut = arbClk_q;
  assign arbitrationClockOeN = testOeN_q;
  assign phyDriveIndicator = linkOeN_q; // see RL5
  assign phyDriveIndicatorOeN = testOeN_q;
  assign receivePrefixFlag = rxPrefix_q;
  assign receivePrefixFlagOeN = testOeN_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  reset_start_a: assert property (@(posedge clk) $fell(reset) |-> state_q == ST_IDLE && !rxPrefix_q) // see RL3
    else $error("state not at start after reset");
  grant_req_a: assert property (@(posedge clk) disable iff (reset) // see RL1
    sysTick && state_q == ST_IDLE && !rxPrefix_q && pins.lreq |=> state_q == ST_GRANT && ctlOut_q == CTL_GRANT)
    else $error("link request not granted");
  drv_enable_a: assert property (@(posedge clk) disable iff (reset) // see RL2
    linkTx && !pins.factTest ##1 1'b1 |=> !extDriverEnableN)
    else $error("driver enable not low during transmit");
  drive_ind_a: assert property (@(posedge clk) disable iff (reset) // see RL5
    state_q != ST_LINK |-> !phyDriveIndicator)
    else $error("indicator high while phy drives");
  test_hiz_a: assert property (@(posedge clk) disable iff (reset) // see RL6
    pins.testDis |=> arbitrationClockOeN && phyDriveIndicatorOeN && receivePrefixFlagOeN)
    else $error("test outputs not released");
  prefix_set_a: assert property (@(posedge clk) disable iff (reset) // see RL7
    !reset && rxEvt |=> receivePrefixFlag [*2])
    else $error("prefix flag not raised");
  sclk_div_a: assert property (@(posedge clk) disable iff (reset) // see RL8
    !reset && oscTick |=> sysClock != $past(sysClock))
    else $error("system clock missed oscillator edge");
  sclk_inv_a: assert property (@(posedge clk) disable iff (reset) // see RL9
    ##1 invertedSystemClock == ~sysClock)
    else $error("inverted clock not complementary");
  ds_encode_a: assert property (@(posedge clk) disable iff (reset) // see RL10
    txStep |=> (txData_q ^ txStrobe_q) != $past(txData_q ^ txStrobe_q))
    else $error("data-strobe phase did not advance");
  rx_pair_a: assert property (@(posedge clk) disable iff (reset) // see RL11
    rxEvt && rxHalf_q |=> rxPair_q == {$past(pins.rxData), $past(rxFirst_q)})
    else $error("received pair wrong");
  ext_pri_a: assert property (@(posedge clk) disable iff (reset) // see RL12
    !reset && extPriEn_q |=> nodePriority == $past(pins.extPri) && busRequestBits == CABLE_REQ_BITS)
    else $error("external priority not taken");
  cable_fmt_a: assert property (@(posedge clk) disable iff (reset) // see RL13
    !extPriEn_q && !reqFmt_q && priorityWriteValid |=> nodePriority == $past(priorityWriteValue))
    else $error("priority write not taken");
  bp_fmt_a: assert property (@(posedge clk) disable iff (reset) // see RL14
    !reset && !extPriEn_q && reqFmt_q |=> busRequestBits == BACKPLANE_REQ_BITS)
    else $error("backplane request width wrong");

  grant_seen_c: cover property (@(posedge clk) disable iff (reset) state_q == ST_GRANT ##[1:40] linkTx);
  recv_seen_c: cover property (@(posedge clk) disable iff (reset) state_q == ST_RECV ##[1:200] state_q == ST_IDLE);
  test_on_c: cover property (@(posedge clk) disable iff (reset) !arbitrationClockOeN);
endmodule

//--- bspc_link_model.sv
/*
  behavioural link-layer partner for the phy pin control bench: requests,
  transmits four pairs, records pairs handed over during receive.
  assumes sysClock from the phy is its clock and the phy owns the two-way
  pins while linkOeN is low.
*/
`timescale 1ns/1ps
module bspc_link_model
  import bspc_pkg::*;
(
  // link clock and phy pin values
  input wire logic sysClock,
  input wire logic [1:0] ctlOut,
  input wire logic [1:0] dataOut,
  input wire logic linkOeN,
  // link request and resolved pins
  output logic linkRequest,
  output logic [1:0] ctlIn,
  output logic [1:0] dataIn,
  // bench control
  input wire logic txGo,
  input wire logic slow,
  input wire logic [7:0] txPairs,
  output logic txDone,
  output logic [1:0] rxLast,
  output logic rxSeen
);
  logic [1:0] ctlDrv = 2'h1;
  logic [1:0] dataDrv = 2'h0;
  int n;
  int i;

  // ----------------------------------------
  // pin resolution
  // ----------------------------------------
  assign ctlIn = linkOeN ? ctlDrv : ctlOut;
  assign dataIn = linkOeN ? dataDrv : dataOut;

  // ----------------------------------------
  // transmit
  // ----------------------------------------
  initial begin
    linkRequest = 1'b0;
    txDone = 1'b0;
    forever begin
      wait (txGo === 1'b1);
      @(posedge sysClock);
      linkRequest <= 1'b1;
      for (n = 0; n < 64 && ctlOut !== CTL_GRANT; n++) @(negedge sysClock);
      linkRequest <= 1'b0;
      ctlDrv <= LINK_TX;
      dataDrv <= txPairs[1:0];
      for (n = 0; n < 64 && linkOeN !== 1'b1; n++) @(negedge sysClock);
      for (i = 1; i < 5; i++) begin
        @(posedge sysClock);
        // slow link holds one period with junk data
        if (slow && i == 2) begin
          ctlDrv <= 2'h1;
          dataDrv <= ~dataDrv;
          @(posedge sysClock);
        end
        ctlDrv <= (i < 4) ? LINK_TX : LINK_IDLE;
        dataDrv <= (i < 4) ? txPairs[2*i +: 2] : ~dataDrv;
      end
      for (n = 0; n < 64 && linkOeN !== 1'b0; n++) @(negedge sysClock);
      txDone <= 1'b1;
      wait (txGo === 1'b0);
      txDone <= 1'b0;
    end
  end

  // ----------------------------------------
  // receive
  // ----------------------------------------
  initial begin
    rxLast = 2'h0;
    rxSeen = 1'b0;
    forever @(negedge sysClock) begin
      if (!linkOeN && ctlOut === CTL_RECEIVE) begin
        rxLast <= dataOut;
        if (dataOut === 2'h2) rxSeen <= 1'b1;
      end
    end
  end
endmodule

//--- bspc_pin_ctrl_bench.sv
/*
  self-checking bench for the phy pin control with a link partner model.
  assumes the design and bspc_link_model are compiled before this file.
*/
`timescale 1ns/1ps
module bspc_pin_ctrl_bench
  import bspc_pkg::*;
;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic oscInHighRate = 1'b0;
  logic oscInLowRate = 1'b0;
  logic oscillatorRateSelect = 1'b0;
  logic rxSerialData = 1'b0;
  logic rxSerialStrobe = 1'b0;
  logic externalPriorityEnable = 1'b0;
  logic requestFormatSelect = 1'b0;
  logic priorityWriteValid = 1'b0;
  logic testOutputDisable = 1'b1;
  logic factoryTestInput = 1'b0;
  logic txGo = 1'b0;
  logic slow = 1'b0;
  logic [PRI_W-1:0] externalPriorityValue = 4'h0;
  logic [PRI_W-1:0] priorityWriteValue = 4'h0;
  logic [7:0] txPairs = 8'h0;
  logic [7:0] txBits = 8'h0;
  logic [1:0] prevTx = 2'h0;
  int txCnt = 0;
  int error_cnt = 0;
  int n_checks = 0;
  logic sysClock, invertedSystemClock, linkRequest, linkOeN, txSerialData, txSerialStrobe, extDriverEnableN;
  logic arbitrationClockOut, arbitrationClockOeN, phyDriveIndicator, phyDriveIndicatorOeN;
  logic receivePrefixFlag, receivePrefixFlagOeN, txDone, rxSeen;
  logic [1:0] ctlIn, ctlOut, dataIn, dataOut, rxLast;
  logic [PRI_W-1:0] nodePriority;
  logic [3:0] busRequestBits;

  always #2.5 clk = ~clk;
  always #32 oscInHighRate = ~oscInHighRate;
  always #64 oscInLowRate = ~oscInLowRate;

  bspc_pin_ctrl u_bspc_pin_ctrl (.clk, .reset, .oscInHighRate, .oscInLowRate, .oscillatorRateSelect, .sysClock,
    .invertedSystemClock, .linkRequest, .ctlIn, .ctlOut, .dataIn, .dataOut, .linkOeN, .txSerialData,
    .txSerialStrobe, .extDriverEnableN, .rxSerialData, .rxSerialStrobe, .externalPriorityEnable,
    .externalPriorityValue, .requestFormatSelect, .priorityWriteValid, .priorityWriteValue, .nodePriority,
    .busRequestBits, .testOutputDisable, .factoryTestInput, .arbitrationClockOut, .arbitrationClockOeN,
    .phyDriveIndicator, .phyDriveIndicatorOeN, .receivePrefixFlag, .receivePrefixFlagOeN);

  bspc_link_model u_bspc_link_model (.sysClock, .ctlOut, .dataOut, .linkOeN, .linkRequest, .ctlIn, .dataIn,
    .txGo, .slow, .txPairs, .txDone, .rxLast, .rxSeen);

  // ----------------------------------------
  // compare and verdict
  // ----------------------------------------
  task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_time(input realtime got, input realtime exp);
    n_checks++;
    if (got < exp - 6.0 || got > exp + 6.0) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, int'(got), int'(exp));
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // clock pair and serial line watch
  always @(negedge clk) begin
    cmp_val(invertedSystemClock, {~sysClock});
    cmp_val(phyDriveIndicator, linkOeN);
    if (reset) begin
      prevTx = {txSerialData, txSerialStrobe};
    end else if ({txSerialData, txSerialStrobe} !== prevTx) begin
      cmp_val(24'($countones({txSerialData, txSerialStrobe} ^ prevTx)), 24'h1);
      if (txCnt % 2 == 1) cmp_val(extDriverEnableN, 1'b0);
      if (txCnt < 8) txBits[txCnt] = txSerialData;
      txCnt++;
      prevTx = {txSerialData, txSerialStrobe};
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic do_reset(input logic rate, input logic extEn, input logic fmt);
    @(posedge clk);
    reset <= 1'b1;
    oscillatorRateSelect <= rate;
    externalPriorityEnable <= extEn;
    requestFormatSelect <= fmt;
    repeat (16) @(posedge clk);
    @(negedge clk);
    cmp_val({sysClock, invertedSystemClock, extDriverEnableN, linkOeN, ctlOut, dataOut, txSerialData,
      txSerialStrobe, nodePriority, busRequestBits, receivePrefixFlag}, 24'h03000e);
    @(posedge clk);
    reset <= 1'b0;
  endtask

  task automatic measure(input logic arb, input int expNs);
    logic prev;
    logic cur;
    int edges;
    realtime t0;
    prev = 1'b1;
    edges = 0;
    t0 = 0;
    for (int k = 0; k < 2000 && edges < 9; k++) begin
      @(negedge clk);
      cur = arb ? arbitrationClockOut : sysClock;
      if (cur === 1'b1 && prev === 1'b0) begin
        if (edges == 0) t0 = $realtime;
        edges++;
      end
      prev = cur;
    end
    cmp_time($realtime - t0, 8.0 * expNs);
    if (edges < 9) begin
      cmp_val(24'h0, 24'h1);
      give_verdict();
    end
  endtask

  task automatic write_pri(input logic [3:0] v);
    @(posedge clk);
    priorityWriteValid <= 1'b1;
    priorityWriteValue <= v;
    @(posedge clk);
    priorityWriteValid <= 1'b0;
    @(negedge clk);
  endtask

  task automatic t_tx(input logic [7:0] pairs, input logic slowLink);
    @(posedge clk);
    txCnt = 0;
    txPairs <= pairs;
    slow <= slowLink;
    txGo <= 1'b1;
    for (int k = 0; k < 4000 && txDone !== 1'b1; k++) @(posedge clk);
    if (txDone !== 1'b1) begin
      cmp_val(24'h0, 24'h1);
      give_verdict();
    end
    txGo <= 1'b0;
    @(negedge clk);
    cmp_val(24'(txCnt), 24'h8);
    cmp_val(txBits, pairs);
    cmp_val({linkOeN, extDriverEnableN}, 2'h1);
  endtask

  task automatic t_test();
    @(negedge clk);
    cmp_val({arbitrationClockOeN, phyDriveIndicatorOeN, receivePrefixFlagOeN}, 3'h7);
    @(posedge clk);
    testOutputDisable <= 1'b0;
    repeat (5) @(negedge clk);
    cmp_val({arbitrationClockOeN, phyDriveIndicatorOeN, receivePrefixFlagOeN}, 3'h0);
    @(posedge clk);
    testOutputDisable <= 1'b1;
    repeat (5) @(negedge clk);
    cmp_val({arbitrationClockOeN, phyDriveIndicatorOeN, receivePrefixFlagOeN}, 3'h7);
  endtask

  task automatic t_cable();
    cmp_val(busRequestBits, 4'h7);
    write_pri(4'h5);
    cmp_val(nodePriority, 4'h5);
    write_pri(4'hf);
    cmp_val(nodePriority, 4'hf);
    t_tx(8'h39, 1'b0);
    cmp_val(nodePriority, 4'hf);
  endtask

  task automatic t_back();
    cmp_val(busRequestBits, 4'hb);
    write_pri(4'h6);
    cmp_val(nodePriority, 4'h0);
    t_tx(8'h39, 1'b1);
    cmp_val(nodePriority, 4'h9);
  endtask

  task automatic t_ext();
    logic [15:0] vals;
    vals = 16'hf910;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      externalPriorityValue <= vals[4*k +: 4];
      repeat (5) @(negedge clk);
      cmp_val(nodePriority, vals[4*k +: 4]);
    end
    write_pri(4'h3);
    cmp_val(nodePriority, 4'hf);
    cmp_val(busRequestBits, 4'h7);
  endtask

  task automatic t_rx();
    logic [3:0] bits;
    int k;
    bits = 4'b0110;
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      if (bits[k] === rxSerialData) rxSerialStrobe <= ~rxSerialStrobe;
      else rxSerialData <= bits[k];
      repeat (12) @(posedge clk);
      if (k == 0) cmp_val(receivePrefixFlag, 1'b1);
    end
    for (k = 0; k < 100 && receivePrefixFlag === 1'b1; k++) @(negedge clk);
    cmp_val(24'(k > 27 && k < 35), 24'h1);
    if (k == 100) give_verdict();
    repeat (80) @(negedge clk);
    cmp_val(ctlOut, CTL_IDLE);
    cmp_val({rxSeen, rxLast}, 3'h5);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset(1'b0, 1'b0, 1'b0);
    measure(1'b0, 128);
    measure(1'b1, 128);
    t_test();
    t_cable();
    t_rx();
    do_reset(1'b1, 1'b0, 1'b1);
    measure(1'b0, 256);
    measure(1'b1, 128);
    t_back();
    // format select high here must be ignored
    do_reset(1'b0, 1'b1, 1'b1);
    t_ext();
    give_verdict();
  end
endmodule
